// >>> logic/regulator_pkg.sv
// Constants shared by the load-adaptive current regulator and its load filter.
// Assumes one 125 MHz clock and a register port with one-cycle strobes.
// Operation
// - Without filtering, a new load value arrives once per motor full step.
// - With filtering on, four successive measurements are averaged into one value.
// - Stall flag output is high while the load value reads zero.
// - Lower threshold is field times 32; a value below it raises current.
// - Upper threshold is (lower plus band plus one) times 32; at/above counts down.
// - Increment step codes 0 to 3 add 1, 2, 4 or 8.
// - Decrement rate codes 0 to 3 need 32, 8, 2 or 1 samples.
// - Both coil values are scaled by (actual current scale plus one) over 32.
// - Lower limit is a quarter of the setting when flagged, else a half.
// - Actual current scale is readable, five bits, biased by one.
// - Actual scale never exceeds the setting nor falls below the chosen minimum.
// - Load value is a ten bit unsigned number; zero means highest load.
// - Stall threshold offset is seven bit signed, handed to the measurement front end.
// - Filtering delivers one load value per four full steps.
package regulator_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned LOAD_W = 10;
    localparam int unsigned SCALE_W = 5;
    localparam int unsigned COIL_W = 8;
    localparam int unsigned OFFSET_W = 7;
    localparam int unsigned THR_W = 11;
    localparam int unsigned CNT_W = 6;
    localparam int unsigned IRQ_W = 4;

    // Register byte addresses
    localparam logic [4:0] ADDR_CONFIG = 5'h00;
    localparam logic [4:0] ADDR_REGULATE = 5'h04;
    localparam logic [4:0] ADDR_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_MASK = 5'h10;

    // Field positions
    localparam int unsigned CFG_SCALE_LSB = 0;
    localparam int unsigned CFG_QUARTER_BIT = 5;
    localparam int unsigned CFG_FILTER_BIT = 6;
    localparam int unsigned CFG_OFFSET_LSB = 8;
    localparam int unsigned REG_LOWER_LSB = 0;
    localparam int unsigned REG_BAND_LSB = 4;
    localparam int unsigned REG_STEP_LSB = 8;
    localparam int unsigned REG_RATE_LSB = 10;
    localparam int unsigned ST_LOAD_LSB = 0;
    localparam int unsigned ST_SCALE_LSB = 16;
    localparam int unsigned ST_STALL_BIT = 24;

    // Interrupt status bits
    localparam int unsigned IRQ_LOAD = 0;
    localparam int unsigned IRQ_STALL = 1;
    localparam int unsigned IRQ_INC = 2;
    localparam int unsigned IRQ_DEC = 3;

    // Arithmetic constants
    localparam int unsigned THRESH_SHIFT = 5;
    localparam int unsigned SCALE_SHIFT = 5;
    localparam int unsigned MIN_SHIFT_QUARTER = 2;
    localparam int unsigned MIN_SHIFT_HALF = 1;
    localparam int unsigned FILTER_SHIFT = 2;
    localparam logic [1:0] FILTER_LAST = 2'h3;
    localparam logic [5:0] DEC_COUNT_0 = 6'h20;
    localparam logic [5:0] DEC_COUNT_1 = 6'h08;
    localparam logic [5:0] DEC_COUNT_2 = 6'h02;
    localparam logic [5:0] DEC_COUNT_3 = 6'h01;

    // Reset values
    localparam logic [4:0] SCALE_RESET = 5'h1f;
    localparam logic [9:0] LOAD_RESET = 10'h3ff;
    localparam logic [3:0] LOWER_RESET = 4'h0;
    localparam logic [3:0] BAND_RESET = 4'h0;
    localparam logic [6:0] OFFSET_RESET = 7'h00;
endpackage : regulator_pkg

// >>> logic/load_link_if.sv
// Load sample path between the regulator and its four-sample filter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface load_link_if;
    logic sample_valid;
    logic [9:0] sample;
    logic enable;
    logic value_valid;
    logic [9:0] value;
    modport filter (input sample_valid, input sample, input enable, output value_valid, output value);
    modport user (output sample_valid, output sample, output enable, input value_valid, input value);
endinterface : load_link_if
`default_nettype wire

// >>> logic/load_filter.sv
// Optional averaging of four load measurements into one value.
// Assumes one raw sample pulse per full step from the front end.
`timescale 1ns/1ps
`default_nettype none
module load_filter
    import regulator_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    load_link_if.filter link
);
    typedef struct packed {
        logic [1:0] cnt;
        logic [11:0] acc;
        logic [9:0] value;
        logic valid;
    } filt_state_s;

    filt_state_s q;
    filt_state_s d;
    logic [11:0] sum;

    // Accumulate, emit on the fourth sample or pass straight through
    always_comb begin
        d = q;
        d.valid = 1'b0;
        sum = q.acc + {2'h0, link.sample};
        if (link.sample_valid) begin
            if (!link.enable) begin
                d.value = link.sample;
                d.valid = 1'b1;
                d.cnt = 2'h0;
                d.acc = 12'h000;
            end else if (q.cnt == FILTER_LAST) begin
                d.value = sum[FILTER_SHIFT +: LOAD_W];
                d.valid = 1'b1;
                d.cnt = 2'h0;
                d.acc = 12'h000;
            end else begin
                d.acc = sum;
                d.cnt = q.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.value = q.value;
    assign link.value_valid = q.valid;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_bypass_pass: assert property (link.sample_valid && !link.enable
        |=> link.value_valid && link.value == $past(link.sample))
        else $error("unfiltered sample not passed through");
    a_filter_hold: assert property (link.sample_valid && link.enable && q.cnt != FILTER_LAST
        |=> !link.value_valid)
        else $error("filter emitted before fourth sample");
    a_filter_emit: assert property (link.sample_valid && link.enable && q.cnt == FILTER_LAST
        |=> link.value_valid)
        else $error("filter missed fourth sample");
endmodule : load_filter
`default_nettype wire

// >>> logic/current_regulator.sv
// Load-adaptive coil current regulator with register port and interrupt.
// Assumes raw load measurements from an analog front end, one pulse per full step,
// and coil magnitudes from a sine table or serial interface, all synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module current_regulator
    import regulator_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic [9:0] raw_load,
    input wire logic raw_load_valid,
    input wire logic [7:0] coil_a_in,
    input wire logic [7:0] coil_b_in,
    output logic [7:0] coil_a_out,
    output logic [7:0] coil_b_out,
    output logic [6:0] stall_threshold_offset,
    output logic stall_flag_output,
    output logic [4:0] actual_current_scale,
    output logic irq
);
    typedef struct packed {
        logic [4:0] coil_scale_setting;
        logic min_current_quarter_flag;
        logic load_filter_enable;
        logic [6:0] offset;
        logic [3:0] lower_load_threshold;
        logic [3:0] upper_band_width;
        logic [1:0] current_increment_step;
        logic [1:0] current_decrement_rate;
        logic [9:0] load_value;
        logic [4:0] scale;
        logic [5:0] dec_cnt;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [31:0] rdata;
        logic [7:0] coil_a;
        logic [7:0] coil_b;
    } reg_state_s;

    reg_state_s q;
    reg_state_s d;

    load_link_if link ();

    load_filter u_filter (
        .clock(clock),
        .reset(reset),
        .link(link.filter)
    );

    // Raw samples enter the filter; the enable comes from software
    assign link.sample_valid = raw_load_valid;
    assign link.sample = raw_load;
    assign link.enable = q.load_filter_enable;

    logic [10:0] lower_thr;
    logic [10:0] upper_thr;
    logic [5:0] upper_sum;
    logic [5:0] step;
    logic [5:0] dec_target;
    logic [5:0] dec_next;
    logic [5:0] inc_sum;
    logic [4:0] scale_min;
    logic [4:0] scale_new;
    logic below;
    logic above;
    logic [3:0] events;
    logic [13:0] prod_a;
    logic [13:0] prod_b;
    logic [5:0] factor;

    // Thresholds from the configured fields, scaled by 32
    always_comb begin
        lower_thr = {2'h0, q.lower_load_threshold, {THRESH_SHIFT{1'b0}}};
        upper_sum = 6'(q.lower_load_threshold) + 6'(q.upper_band_width) + 6'h01;
        upper_thr = {upper_sum, {THRESH_SHIFT{1'b0}}};
        below = {1'b0, link.value} < lower_thr;
        above = {1'b0, link.value} >= upper_thr;
    end

    // Step width and decrement sample count from their codes
    always_comb begin
        step = 6'h01 << q.current_increment_step;
        case (q.current_decrement_rate)
            2'h0: dec_target = DEC_COUNT_0;
            2'h1: dec_target = DEC_COUNT_1;
            2'h2: dec_target = DEC_COUNT_2;
            2'h3: dec_target = DEC_COUNT_3;
            default: dec_target = DEC_COUNT_0;
        endcase
    end

    // Coil scaling uses the biased factor, so an actual scale of 31 passes full value
    always_comb begin
        factor = {1'b0, q.scale} + 6'h01;
        prod_a = 14'(coil_a_in) * 14'(factor);
        prod_b = 14'(coil_b_in) * 14'(factor);
    end

    // Register writes, regulation and interrupt status in one next-state process
    always_comb begin
        d = q;
        events = 4'h0;
        dec_next = q.dec_cnt + 6'h01;
        inc_sum = 6'h00;
        scale_new = q.scale;
        scale_min = 5'h00;

        // Software writes
        if (wr_en) begin
            case (addr)
                ADDR_CONFIG: begin
                    d.coil_scale_setting = wdata[CFG_SCALE_LSB +: SCALE_W];
                    d.min_current_quarter_flag = wdata[CFG_QUARTER_BIT];
                    d.load_filter_enable = wdata[CFG_FILTER_BIT];
                    d.offset = wdata[CFG_OFFSET_LSB +: OFFSET_W];
                end
                ADDR_REGULATE: begin
                    d.lower_load_threshold = wdata[REG_LOWER_LSB +: 4];
                    d.upper_band_width = wdata[REG_BAND_LSB +: 4];
                    d.current_increment_step = wdata[REG_STEP_LSB +: 2];
                    d.current_decrement_rate = wdata[REG_RATE_LSB +: 2];
                end
                ADDR_IRQ_MASK: begin
                    d.irq_mask = wdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Only a fresh load value runs the increment and decrement steps
        if (link.value_valid) begin
            d.load_value = link.value;
            events[IRQ_LOAD] = 1'b1;
            if (link.value == '0 && q.load_value != '0) begin
                events[IRQ_STALL] = 1'b1;
            end
            if (below) begin
                inc_sum = {1'b0, q.scale} + step;
                scale_new = (inc_sum > {1'b0, d.coil_scale_setting}) ? d.coil_scale_setting : inc_sum[4:0];
                d.dec_cnt = 6'h00;
                events[IRQ_INC] = scale_new != q.scale;
            end else if (above) begin
                if (dec_next >= dec_target) begin
                    scale_new = (q.scale == 5'h00) ? 5'h00 : q.scale - 5'h01;
                    d.dec_cnt = 6'h00;
                    events[IRQ_DEC] = 1'b1;
                end else begin
                    d.dec_cnt = dec_next;
                end
            end
        end

        // Clamp against the new setting so a write takes effect at once
        scale_min = d.min_current_quarter_flag ? (d.coil_scale_setting >> MIN_SHIFT_QUARTER)
                                               : (d.coil_scale_setting >> MIN_SHIFT_HALF);
        if (scale_new > d.coil_scale_setting) begin
            scale_new = d.coil_scale_setting;
        end
        if (scale_new < scale_min) begin
            scale_new = scale_min;
        end
        d.scale = scale_new;

        // Read data, one cycle after the strobe; unmapped reads answer zero
        d.rdata = '0;
        if (rd_en) begin
            case (addr)
                ADDR_CONFIG: begin
                    d.rdata[CFG_SCALE_LSB +: SCALE_W] = q.coil_scale_setting;
                    d.rdata[CFG_QUARTER_BIT] = q.min_current_quarter_flag;
                    d.rdata[CFG_FILTER_BIT] = q.load_filter_enable;
                    d.rdata[CFG_OFFSET_LSB +: OFFSET_W] = q.offset;
                end
                ADDR_REGULATE: begin
                    d.rdata[REG_LOWER_LSB +: 4] = q.lower_load_threshold;
                    d.rdata[REG_BAND_LSB +: 4] = q.upper_band_width;
                    d.rdata[REG_STEP_LSB +: 2] = q.current_increment_step;
                    d.rdata[REG_RATE_LSB +: 2] = q.current_decrement_rate;
                end
                ADDR_STATUS: begin
                    d.rdata[ST_LOAD_LSB +: LOAD_W] = q.load_value;
                    d.rdata[ST_SCALE_LSB +: SCALE_W] = q.scale;
                    d.rdata[ST_STALL_BIT] = stall_flag_output;
                end
                ADDR_IRQ_STATUS: begin
                    d.rdata[IRQ_W-1:0] = q.irq_stat;
                end
                ADDR_IRQ_MASK: begin
                    d.rdata[IRQ_W-1:0] = q.irq_mask;
                end
                default: begin
                end
            endcase
        end

        // Read clears the status, but an event in the same cycle survives
        if (rd_en && addr == ADDR_IRQ_STATUS) begin
            d.irq_stat = events;
        end else begin
            d.irq_stat = q.irq_stat | events;
        end

        // Registered coil values keep the outputs glitch free
        d.coil_a = prod_a[SCALE_SHIFT +: COIL_W];
        d.coil_b = prod_b[SCALE_SHIFT +: COIL_W];
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.coil_scale_setting <= SCALE_RESET;
            q.offset <= OFFSET_RESET;
            q.lower_load_threshold <= LOWER_RESET;
            q.upper_band_width <= BAND_RESET;
            q.load_value <= LOAD_RESET;
            q.scale <= SCALE_RESET;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign rdata = q.rdata;
    assign coil_a_out = q.coil_a;
    assign coil_b_out = q.coil_b;
    assign stall_threshold_offset = q.offset;
    assign stall_flag_output = q.load_value == '0;
    assign actual_current_scale = q.scale;
    assign irq = |(q.irq_stat & q.irq_mask);

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_scale_ceiling: assert property (q.scale <= q.coil_scale_setting)
        else $error("actual scale above setting");
    a_scale_floor: assert property (q.min_current_quarter_flag
        |-> q.scale >= (q.coil_scale_setting >> MIN_SHIFT_QUARTER))
        else $error("actual scale below quarter limit");
    // Half limit is the default floor and needs its own guard
    a_half_floor: assert property (!q.min_current_quarter_flag
        |-> q.scale >= (q.coil_scale_setting >> MIN_SHIFT_HALF))
        else $error("actual scale below half limit");
    a_stall_zero: assert property (link.value_valid && link.value == '0 |=> stall_flag_output)
        else $error("stall flag not raised on zero load");
    a_load_refresh: assert property (link.value_valid |=> q.load_value == $past(link.value))
        else $error("load value not refreshed");
    a_scale_idle: assert property (!link.value_valid && !wr_en |=> $stable(q.scale))
        else $error("scale moved without a new load value");
    a_inc_rises: assert property (link.value_valid && below && !wr_en && q.scale < q.coil_scale_setting
        |=> q.scale > $past(q.scale))
        else $error("current not raised below lower threshold");
    a_dec_single: assert property (link.value_valid && above && !wr_en && q.current_decrement_rate == 2'h3
        && q.scale > (q.coil_scale_setting >> MIN_SHIFT_QUARTER) && q.min_current_quarter_flag
        |=> q.scale == $past(q.scale) - 5'h01)
        else $error("rate three did not decrement at once");
    a_coil_scaling: assert property (q.scale == SCALE_RESET && $stable(q.scale)
        |=> coil_a_out == $past(coil_a_in))
        else $error("full scale did not pass coil value");
    // Second coil shares the scale path with the first
    a_coil_b_full: assert property (q.scale == SCALE_RESET
        |=> coil_b_out == $past(coil_b_in))
        else $error("full scale did not pass coil b");

    // A non-zero load drops the stall flag at once
    a_stall_clear: assert property (link.value_valid && link.value != '0 |=> !stall_flag_output)
        else $error("stall flag kept on non-zero load");
    // A low sample restarts the slow decrement count
    a_count_restart: assert property (link.value_valid && below |=> q.dec_cnt == '0)
        else $error("decrement count not restarted");
    // Upper band samples advance the count until it is used
    a_count_step: assert property (link.value_valid && above && dec_next < dec_target
        |=> q.dec_cnt == $past(dec_next))
        else $error("decrement count not advanced");
    // Without a write the clamp is fixed, so direction follows the sample
    a_low_raises: assert property (link.value_valid && below && !wr_en |=> q.scale >= $past(q.scale))
        else $error("scale fell on a low sample");
    a_high_lowers: assert property (link.value_valid && !below && !wr_en |=> q.scale <= $past(q.scale))
        else $error("scale rose without a low sample");

    // Status word carries the scale of the strobe cycle
    a_status_scale: assert property (rd_en && addr == ADDR_STATUS
        |=> rdata[ST_SCALE_LSB +: SCALE_W] == $past(q.scale))
        else $error("status read lost the actual scale");
    // The offset reaches the front end as written
    a_offset_write: assert property (wr_en && addr == ADDR_CONFIG
        |=> stall_threshold_offset == $past(wdata[CFG_OFFSET_LSB +: OFFSET_W]))
        else $error("offset not handed to front end");
    // Event bits: a set beats a clearing read in the same cycle
    a_inc_event: assert property (link.value_valid && below && !wr_en && q.scale < q.coil_scale_setting
        |=> q.irq_stat[IRQ_INC])
        else $error("increase event lost");
    a_dec_event: assert property (link.value_valid && above && dec_next >= dec_target |=> q.irq_stat[IRQ_DEC])
        else $error("decrement event lost");
    a_load_event: assert property (link.value_valid |=> q.irq_stat[IRQ_LOAD])
        else $error("new load event lost");
endmodule : current_regulator
`default_nettype wire

// >>> test/front_end_model.sv
// Behavioural load-measurement front end feeding raw samples to the regulator.
// Assumes the bench calls send once per full step; one clock shared with the regulator.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
    input wire logic clock,
    output logic [9:0] raw_load,
    output logic raw_load_valid
);
    // Idle outputs at time zero
    initial begin
        raw_load = 10'h000;
        raw_load_valid = 1'b0;
    end

    // One measurement per full step, a single-cycle pulse
    task send(input logic [9:0] v);
        @(posedge clock);
        raw_load <= v;
        raw_load_valid <= 1'b1;
        @(posedge clock);
        raw_load_valid <= 1'b0;
        raw_load <= ~v; // Stale data inverted so nothing leans on a held value
    endtask : send
endmodule : front_end_model
`default_nettype wire

// >>> test/load_adaptive_current_regulator_tb.sv
// Self-checking bench for the load-adaptive current regulator.
// Assumes the front end model drives raw samples; the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none
module load_adaptive_current_regulator_tb;
    import regulator_pkg::*;
    logic clock, reset, wr_en, rd_en, raw_load_valid, stall_flag_output, irq;
    logic [4:0] addr, actual_current_scale;
    logic [31:0] wdata, rdata;
    logic [9:0] raw_load;
    logic [7:0] coil_a, coil_b, coil_a_out, coil_b_out;
    logic [6:0] stall_threshold_offset;
    int n_errors, cmp_count, cnt, grp, acc;
    logic [4:0] setting, scl, prev;
    logic quarter, filt;
    logic [3:0] lower, band;
    logic [1:0] step, rate;
    logic [9:0] load_e, v;

    current_regulator i_dut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .raw_load(raw_load), .raw_load_valid(raw_load_valid),
        .coil_a_in(coil_a), .coil_b_in(coil_b), .coil_a_out(coil_a_out), .coil_b_out(coil_b_out),
        .stall_threshold_offset(stall_threshold_offset), .stall_flag_output(stall_flag_output),
        .actual_current_scale(actual_current_scale), .irq(irq));
    front_end_model i_front (.clock(clock), .raw_load(raw_load), .raw_load_valid(raw_load_valid));

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task test_done();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task check(input bit ok, input string what);
        cmp_count++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check

    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    // Read data is looked at in the one cycle after the strobe
    task rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, input string what);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check((rdata & m) === (e & m), what);
    endtask : rd

    // Clamp between the selected minimum and the coil scale setting
    function automatic logic [4:0] lim(input int s);
        int lo;
        lo = quarter ? (setting >> 2) : (setting >> 1);
        if (s > int'(setting)) return setting;
        if (s < lo) return 5'(lo);
        return 5'(s);
    endfunction : lim

    // Expected regulator reaction to one delivered load value
    function automatic void reg_step(input logic [9:0] x);
        int need;
        need = (rate == 2'h0) ? 32 : (rate == 2'h1) ? 8 : (rate == 2'h2) ? 2 : 1;
        if (x < lower * 32) begin
            scl = lim(scl + (1 << step));
            cnt = 0;
        end else if (x >= (lower + band + 1) * 32) begin
            cnt++;
            if (cnt >= need) begin
                scl = lim(scl - 1);
                cnt = 0;
            end
        end
    endfunction : reg_step

    task set_cfg(input logic [4:0] s, input logic q, input logic f, input logic [6:0] o);
        setting = s;
        quarter = q;
        filt = f;
        wr(ADDR_CONFIG, {17'h0, o, 1'b0, f, q, s});
        scl = lim(scl);
        repeat (2) @(posedge clock);
        #1;
        check(stall_threshold_offset === o, "offset");
        check(actual_current_scale === scl, "clamp");
    endtask : set_cfg

    task set_reg(input logic [3:0] l, input logic [3:0] b, input logic [1:0] su, input logic [1:0] r);
        lower = l;
        band = b;
        step = su;
        rate = r;
        wr(ADDR_REGULATE, {20'h0, r, su, b, l});
    endtask : set_reg

    // One full-step sample, then scale, both coils, stall flag and status word are compared
    task sample(input logic [9:0] x);
        @(posedge clock);
        coil_a <= 8'($urandom);
        coil_b <= 8'($urandom);
        i_front.send(x);
        if (filt) begin
            acc += x;
            grp++;
            if (grp == 4) begin
                load_e = 10'(acc >> 2);
                acc = 0;
                grp = 0;
                reg_step(load_e);
            end
        end else begin
            load_e = x;
            reg_step(x);
        end
        repeat (3) @(posedge clock);
        #1;
        check(actual_current_scale === scl, "scale");
        check(coil_a_out === 8'((coil_a * (scl + 1)) >> 5), "coil a");
        check(coil_b_out === 8'((coil_b * (scl + 1)) >> 5), "coil b");
        check(stall_flag_output === (load_e == 10'h0), "stall");
        rd(ADDR_STATUS, {7'h0, load_e == 10'h0, 3'h0, scl, 6'h0, load_e}, 32'hffffffff, "status");
    endtask : sample

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("mismatch at %0t: watchdog", $time);
        test_done();
    end

    initial begin
        void'($urandom(32'hdabd0eba));
        {wr_en, rd_en, addr, wdata, coil_a, coil_b} = '0;
        reset = 1'b1;
        {n_errors, cmp_count, cnt, grp, acc} = '0;
        {quarter, filt, lower, band, step, rate} = '0;
        setting = 5'h1f;
        scl = 5'h1f;
        load_e = 10'h3ff;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        // Reset values, unmapped place, answer standing one cycle only
        rd(ADDR_CONFIG, 32'h0000001f, 32'hffffffff, "config reset");
        rd(ADDR_REGULATE, 32'h0, 32'hffffffff, "regulate reset");
        rd(ADDR_STATUS, 32'h001f03ff, 32'hffffffff, "status reset");
        check(irq === 1'b0 && stall_flag_output === 1'b0, "reset outputs");
        rd(5'h14, 32'h0, 32'hffffffff, "unmapped read");
        @(posedge clock);
        #1;
        check(rdata === 32'h0, "rdata after answer");
        wr(5'h14, 32'hffffffff);
        rd(ADDR_CONFIG, 32'h0000001f, 32'hffffffff, "unmapped write");
        set_cfg(5'h14, 1'b0, 1'b0, 7'h76); // Negative offset for a sensitive stall reading
        // Every step and rate code, both minimum modes, random loads biased high
        for (int ph = 0; ph < 8; ph++) begin
            set_cfg(5'($urandom_range(4, 31)), ph[0], 1'b0, 7'($urandom));
            set_reg(4'($urandom_range(1, 15)), 4'($urandom), 2'(ph), 2'(ph >> 1));
            sample(10'h000); // Restarts the decrement count
            repeat (40) begin
                if ($urandom_range(0, 15) == 0) v = 10'($urandom_range(0, lower * 32 - 1));
                else v = 10'($urandom_range((lower + band + 1) * 32, 1023));
                sample(v);
            end
        end
        // Threshold boundaries: lower 64, upper exactly 96, slowest decrement rate
        set_reg(4'h2, 4'h0, 2'h0, 2'h0);
        sample(10'd63);
        sample(10'd64);
        repeat (32) sample(10'd96);
        // Averaged groups of four
        set_cfg(5'h18, 1'b1, 1'b1, 7'h00); // Precision measurement wanted here
        repeat (8) sample(10'($urandom));
        set_cfg(5'h18, 1'b1, 1'b0, 7'h00); // Fast stall reaction
        // Stall event raises the interrupt, the read clears it, the mask hides it
        wr(ADDR_IRQ_MASK, 32'h1 << IRQ_STALL);
        rd(ADDR_IRQ_MASK, 32'h1 << IRQ_STALL, 32'hffffffff, "mask readback");
        sample(10'd5);
        // Load and stall events are pending since the first phase
        rd(ADDR_IRQ_STATUS, 32'h3, 32'hfffffff3, "clear status");
        prev = scl;
        sample(10'd0);
        check(irq === 1'b1, "irq on stall");
        rd(ADDR_IRQ_STATUS, {28'h0, 1'b0, scl != prev, 2'h3}, 32'hffffffff, "irq status");
        @(posedge clock);
        #1;
        check(irq === 1'b0, "irq after clear");
        wr(ADDR_IRQ_MASK, 32'h0);
        sample(10'd7);
        sample(10'd0);
        check(irq === 1'b0, "irq masked");
        test_done();
    end
endmodule : load_adaptive_current_regulator_tb
`default_nettype wire
